// *** gha_pkg.sv ***
// gauge history and alarm register bank: shared constants and carrier types
// assumes 16-bit register words addressed by an 8-bit command code
package gha_pkg;
  // register command codes
  localparam logic [7:0] ADDR_FLAGS     = 8'h19;
  localparam logic [7:0] ADDR_HIGH_TEMP = 8'h21;
  localparam logic [7:0] ADDR_RUN_LO    = 8'h24;
  localparam logic [7:0] ADDR_RUN_HI    = 8'h25;
  localparam logic [7:0] ADDR_TACC_LO   = 8'h26;
  localparam logic [7:0] ADDR_TACC_HI   = 8'h27;
  localparam logic [7:0] ADDR_CACC_LO   = 8'h28;
  localparam logic [7:0] ADDR_CACC_HI   = 8'h29;
  localparam logic [7:0] ADDR_VMAX      = 8'h2A;
  localparam logic [7:0] ADDR_VMIN      = 8'h2B;
  localparam logic [7:0] ADDR_TMAX      = 8'h2C;
  localparam logic [7:0] ADDR_TMIN      = 8'h2D;
  localparam logic [7:0] ADDR_AMBIENT   = 8'h30;
  localparam logic [7:0] ADDR_HEALTH    = 8'h32;
  localparam logic [7:0] ADDR_UID_LO    = 8'h36;
  localparam logic [7:0] ADDR_UID_HI    = 8'h37;
  // fields and initial values
  localparam int          FLAG_HIGH_TEMP_BIT = 12;
  localparam int          THERM_CELL_BIT     = 0;
  localparam int          THERM_AMB_BIT      = 1;
  localparam logic [15:0] MODE_OPERATIONAL   = 16'h0001;
  localparam logic [15:0] MODE_SLEEP         = 16'h0002;
  localparam logic [31:0] RUNTIME_SAT        = 32'h00FFFFFF;
  localparam logic [31:0] CHARGE_SAT         = 32'h0FFFFFFF;
  localparam logic [15:0] AMBIENT_MIN        = 16'h0980;
  localparam logic [15:0] AMBIENT_MAX        = 16'h0DCC;
  localparam logic [15:0] HEALTH_INIT        = 16'h0064;
  localparam logic [15:0] VMIN_INIT          = 16'hFFFF;
  localparam logic [15:0] TMIN_INIT          = 16'hFFFF;
  // timing
  localparam longint CLK_HZ         = 20000000;
  localparam longint MINUTE_S       = 60;
  localparam longint MINUTE_CYCLES  = CLK_HZ * MINUTE_S;
  localparam longint INIT_TIME_US   = 1000;
  localparam longint INIT_CYCLES    = (CLK_HZ * INIT_TIME_US) / 1000000;
  localparam longint FAST_SAMPLE_MS = 250;
  localparam longint SLOW_SAMPLE_MS = 1000;
  localparam longint FAST_CYCLES    = (CLK_HZ * FAST_SAMPLE_MS) / 1000;
  localparam longint SLOW_CYCLES    = (CLK_HZ * SLOW_SAMPLE_MS) / 1000;

  typedef struct packed {
    logic [15:0] voltage;
    logic [15:0] temperature;
    logic [15:0] openCircuit;
    logic [15:0] impedance;
    logic [15:0] chargeLevel;
  } gha_meas_s;

  typedef struct packed {
    logic        strobe;
    logic [7:0]  addr;
    logic [15:0] data;
  } gha_write_s;
endpackage

// *** gha_regs.sv ***
// gauge history and alarm register bank with its two-wire serial slave
// assumes scl/sda inputs already synchronous to ref_clk, measurements
// arrive as one-cycle strobes from the converter front end
`timescale 1ns/1ps
module gha_regs #(
  parameter logic [6:0]  DEV_ADDR      = 7'h2A,
  parameter longint      MINUTE_TICKS  = gha_pkg::MINUTE_CYCLES,
  parameter longint      INIT_TICKS    = gha_pkg::INIT_CYCLES,
  parameter longint      FAST_TICKS    = gha_pkg::FAST_CYCLES,
  parameter longint      SLOW_TICKS    = gha_pkg::SLOW_CYCLES,
  parameter logic [15:0] RELEASE_MV    = 16'h0A00,
  parameter logic [15:0] CURRENT_DELTA = 16'h0010
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // serial register port
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe,
  // front end
  input  wire logic              insertDetect,
  input  wire logic              cellMeasValid,
  input  wire gha_pkg::gha_meas_s cellMeas,
  input  wire logic              ambientValid,
  input  wire logic [15:0]       ambientRaw,
  input  wire logic              healthStep,
  input  wire logic [31:0]       nvmUserId,
  input  wire logic [15:0]       powerMode,
  input  wire logic [1:0]        thermCtrl,
  // outputs
  output logic                   alarm_out_n,
  output logic                   ready,
  output logic                   measReq,
  output logic signed [15:0]     loadCurrent,
  output logic signed [31:0]     chargeCount
);
  initial begin
    if (MINUTE_TICKS < 2 || INIT_TICKS < 1 || FAST_TICKS < 2 || SLOW_TICKS < FAST_TICKS)
      $error("gha_regs: timing parameters out of range");
  end

  typedef enum logic [1:0] {PwrReset, PwrInit, PwrReady} gha_pwr_e;
  typedef enum logic [2:0] {BusIdle, BusRecv, BusAck, BusSend, BusAckIn} gha_bus_e;

  gha_pwr_e   pwrQ;
  logic [31:0] initCntQ;
  logic        clrAll;
  logic        opMode;
  assign clrAll = srst || pwrQ == PwrReset;
  assign opMode = pwrQ == PwrReady && powerMode == gha_pkg::MODE_OPERATIONAL;

  // insertion restarts the whole bank; init window ends in ready
  always_ff @(posedge ref_clk) begin
    if (srst || insertDetect) begin
      pwrQ     <= PwrReset;
      initCntQ <= '0;
    end else begin
      case (pwrQ)
        PwrReset: if (cellMeasValid && cellMeas.voltage > RELEASE_MV) pwrQ <= PwrInit;
        PwrInit: begin
          initCntQ <= initCntQ + 32'h1;
          if (initCntQ == 32'(INIT_TICKS - 1)) pwrQ <= PwrReady;
        end
        PwrReady: pwrQ <= PwrReady;
        default:  pwrQ <= PwrReset;
      endcase
    end
  end
  always_ff @(posedge ref_clk) ready <= !clrAll && pwrQ == PwrReady;

  // serial slave: addr, command, then low byte, high byte
  logic       sclQ, sdaQ, sclRise, sclFall, startC, stopC;
  gha_bus_e   busQ;
  logic [2:0] bitCntQ;
  logic [7:0] shiftQ, cmdQ, loByteQ;
  logic [1:0] byteIdxQ;
  logic       rnwQ, hiSendQ;
  logic [15:0] rdWord;
  gha_pkg::gha_write_s wr;
  assign sclRise = sclIn && !sclQ;
  assign sclFall = !sclIn && sclQ;
  assign startC  = sclIn && sclQ && sdaQ && !sdaIn;
  assign stopC   = sclIn && sclQ && !sdaQ && sdaIn;

  always_ff @(posedge ref_clk) begin
    sclQ <= srst ? 1'b1 : sclIn;
    sdaQ <= srst ? 1'b1 : sdaIn;
  end

  always_ff @(posedge ref_clk) begin
    wr.strobe <= 1'b0;
    if (clrAll || stopC) begin
      busQ <= BusIdle;
      sdaOe <= 1'b0;
      bitCntQ <= '0;
      byteIdxQ <= '0;
      rnwQ <= 1'b0;
      hiSendQ <= 1'b0;
      shiftQ <= '0;
      wr.addr <= '0;
      wr.data <= '0;
      if (clrAll) begin
        cmdQ <= '0;
        loByteQ <= '0;
      end
    end else if (startC) begin
      busQ <= BusRecv;
      sdaOe <= 1'b0;
      bitCntQ <= '0;
      byteIdxQ <= '0;
      hiSendQ <= 1'b0;
    end else begin
      case (busQ)
        BusRecv: if (sclRise) begin
          shiftQ <= {shiftQ[6:0], sdaIn};
          bitCntQ <= bitCntQ + 3'h1;
          if (bitCntQ == 3'h7) busQ <= BusAck;
        end
        BusAck: if (sclFall) begin
          if (sdaOe) begin
            sdaOe <= 1'b0;
            byteIdxQ <= byteIdxQ == 2'h3 ? 2'h2 : byteIdxQ + 2'h1;
            busQ <= (byteIdxQ == 2'h0 && rnwQ) ? BusSend : BusRecv;
            if (byteIdxQ == 2'h0 && rnwQ) sdaOe <= !rdWord[7];
          end else if (byteIdxQ == 2'h0 && shiftQ[7:1] != DEV_ADDR) begin
            busQ <= BusIdle;
          end else begin
            sdaOe <= 1'b1;
            case (byteIdxQ)
              2'h0: rnwQ <= shiftQ[0];
              2'h1: cmdQ <= shiftQ;
              2'h2: loByteQ <= shiftQ;
              default: begin
                wr.strobe <= 1'b1;
                wr.addr <= cmdQ;
                wr.data <= {shiftQ, loByteQ};
              end
            endcase
          end
        end
        BusSend: if (sclFall) begin
          bitCntQ <= bitCntQ + 3'h1;
          if (bitCntQ == 3'h7) begin
            sdaOe <= 1'b0;
            busQ <= BusAckIn;
          end else begin
            sdaOe <= hiSendQ ? !rdWord[4'(5'd14 - bitCntQ)] : !rdWord[3'(3'd6 - bitCntQ)];
          end
        end
        // host ack still stands at the clock fall; next msb goes out then
        BusAckIn: if (sclFall) begin
          busQ <= sdaIn ? BusIdle : BusSend;
          hiSendQ <= !hiSendQ;
          sdaOe <= !sdaIn && (hiSendQ ? !rdWord[7] : !rdWord[15]);
        end
        default: busQ <= BusIdle;
      endcase
    end
  end
  always_ff @(posedge ref_clk) sdaOut <= 1'b0;

  // register state
  logic [15:0] highTempQ, flagsQ, vMaxQ, vMinQ, tMaxQ, tMinQ, ambientQ, healthQ;
  logic [31:0] runQ, tAccQ, cAccQ;
  logic [15:0] runLoStageQ, tAccLoStageQ, cAccLoStageQ;
  logic [31:0] minuteCntQ;
  logic        minuteTick, hotNow, alarmEn, wrHit;
  assign alarmEn = highTempQ != 16'h0 && thermCtrl[gha_pkg::THERM_CELL_BIT];
  assign hotNow  = alarmEn && cellMeas.temperature > highTempQ;
  assign minuteTick = opMode && minuteCntQ == 32'(MINUTE_TICKS - 1);
  assign wrHit = wr.strobe;

  always_ff @(posedge ref_clk) begin
    if (clrAll || !opMode) minuteCntQ <= '0;
    else minuteCntQ <= minuteTick ? 32'h0 : minuteCntQ + 32'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (clrAll) begin
      highTempQ <= '0;
      flagsQ <= '0;
      alarm_out_n <= 1'b1;
    end else begin
      if (wrHit && wr.addr == gha_pkg::ADDR_HIGH_TEMP) highTempQ <= wr.data;
      if (wrHit && wr.addr == gha_pkg::ADDR_FLAGS) flagsQ <= wr.data;
      if (cellMeasValid && hotNow && opMode)
        flagsQ[gha_pkg::FLAG_HIGH_TEMP_BIT] <= 1'b1;
      if (!opMode || !alarmEn) alarm_out_n <= 1'b1;
      else if (cellMeasValid) alarm_out_n <= !hotNow;
    end
  end

  // accumulators: low word staged, high-word write commits both
  always_ff @(posedge ref_clk) begin
    if (clrAll) begin
      runQ <= '0;
      tAccQ <= '0;
      cAccQ <= '0;
      runLoStageQ <= '0;
      tAccLoStageQ <= '0;
      cAccLoStageQ <= '0;
    end else begin
      if (minuteTick && runQ < gha_pkg::RUNTIME_SAT) runQ <= runQ + 32'h1;
      if (minuteTick)
        cAccQ <= (CHARGE_SUM(cAccQ, cellMeas.chargeLevel));
      if (wrHit) begin
        case (wr.addr)
          gha_pkg::ADDR_RUN_LO:  runLoStageQ <= wr.data;
          gha_pkg::ADDR_RUN_HI:  runQ <= {wr.data, runLoStageQ};
          gha_pkg::ADDR_TACC_LO: tAccLoStageQ <= wr.data;
          gha_pkg::ADDR_TACC_HI: tAccQ <= {wr.data, tAccLoStageQ};
          gha_pkg::ADDR_CACC_LO: cAccLoStageQ <= wr.data;
          gha_pkg::ADDR_CACC_HI: cAccQ <= {wr.data, cAccLoStageQ};
          default: ;
        endcase
      end
    end
  end

  function automatic logic [31:0] CHARGE_SUM(input logic [31:0] acc, input logic [15:0] lvl);
    logic [32:0] s;
    s = {1'b0, acc} + {17'h0, lvl};
    return (s >= {1'b0, gha_pkg::CHARGE_SAT}) ? gha_pkg::CHARGE_SAT : s[31:0];
  endfunction

  // trackers; a write wins over a sample in the same cycle
  always_ff @(posedge ref_clk) begin
    if (clrAll) begin
      vMaxQ <= '0;
      vMinQ <= gha_pkg::VMIN_INIT;
      tMaxQ <= '0;
      tMinQ <= gha_pkg::TMIN_INIT;
    end else if (wrHit && wr.addr inside {gha_pkg::ADDR_VMAX, gha_pkg::ADDR_VMIN,
                                          gha_pkg::ADDR_TMAX, gha_pkg::ADDR_TMIN}) begin
      if (wr.addr == gha_pkg::ADDR_VMAX) vMaxQ <= wr.data;
      if (wr.addr == gha_pkg::ADDR_VMIN) vMinQ <= wr.data;
      if (wr.addr == gha_pkg::ADDR_TMAX) tMaxQ <= wr.data;
      if (wr.addr == gha_pkg::ADDR_TMIN) tMinQ <= wr.data;
    end else if (cellMeasValid && opMode) begin
      if (cellMeas.voltage > vMaxQ) vMaxQ <= cellMeas.voltage;
      if (cellMeas.voltage < vMinQ) vMinQ <= cellMeas.voltage;
      if (thermCtrl[gha_pkg::THERM_CELL_BIT] && cellMeas.temperature > tMaxQ)
        tMaxQ <= cellMeas.temperature;
      if (thermCtrl[gha_pkg::THERM_CELL_BIT] && cellMeas.temperature < tMinQ)
        tMinQ <= cellMeas.temperature;
    end
  end

  // ambient is report-only and never reaches the charge path
  always_ff @(posedge ref_clk) begin
    if (clrAll) ambientQ <= gha_pkg::AMBIENT_MIN;
    else if (ambientValid && opMode && thermCtrl[gha_pkg::THERM_AMB_BIT])
      ambientQ <= ambientRaw < gha_pkg::AMBIENT_MIN ? gha_pkg::AMBIENT_MIN :
                  ambientRaw > gha_pkg::AMBIENT_MAX ? gha_pkg::AMBIENT_MAX : ambientRaw;
  end

  always_ff @(posedge ref_clk) begin
    if (clrAll) healthQ <= gha_pkg::HEALTH_INIT;
    else if (healthStep && healthQ != 16'h0) healthQ <= healthQ - 16'h1;
  end

  // current estimate; rate switches fast while current moves
  logic signed [16:0] varied;
  logic signed [15:0] curNow;
  logic [31:0]        sampleCntQ;
  logic               fastQ;
  assign varied = $signed({1'b0, cellMeas.voltage}) - $signed({1'b0, cellMeas.openCircuit});
  assign curNow = cellMeas.impedance == 16'h0 ? 16'sh0 :
                  16'(varied / $signed({1'b0, cellMeas.impedance}));

  always_ff @(posedge ref_clk) begin
    if (clrAll) begin
      loadCurrent <= '0;
      chargeCount <= '0;
      fastQ <= 1'b0;
    end else if (cellMeasValid && opMode) begin
      loadCurrent <= curNow;
      chargeCount <= chargeCount + 32'(curNow);
      fastQ <= (curNow > loadCurrent ? curNow - loadCurrent : loadCurrent - curNow)
               > $signed(CURRENT_DELTA);
    end
  end

  always_ff @(posedge ref_clk) begin
    measReq <= 1'b0;
    if (clrAll || !opMode) sampleCntQ <= '0;
    else if (sampleCntQ >= 32'((fastQ ? FAST_TICKS : SLOW_TICKS) - 1)) begin
      sampleCntQ <= '0;
      measReq <= 1'b1;
    end else sampleCntQ <= sampleCntQ + 32'h1;
  end

  always_comb begin
    case (cmdQ)
      gha_pkg::ADDR_FLAGS:     rdWord = flagsQ;
      gha_pkg::ADDR_HIGH_TEMP: rdWord = highTempQ;
      gha_pkg::ADDR_RUN_LO:    rdWord = runQ[15:0];
      gha_pkg::ADDR_RUN_HI:    rdWord = runQ[31:16];
      gha_pkg::ADDR_TACC_LO:   rdWord = tAccQ[15:0];
      gha_pkg::ADDR_TACC_HI:   rdWord = tAccQ[31:16];
      gha_pkg::ADDR_CACC_LO:   rdWord = cAccQ[15:0];
      gha_pkg::ADDR_CACC_HI:   rdWord = cAccQ[31:16];
      gha_pkg::ADDR_VMAX:      rdWord = vMaxQ;
      gha_pkg::ADDR_VMIN:      rdWord = vMinQ;
      gha_pkg::ADDR_TMAX:      rdWord = tMaxQ;
      gha_pkg::ADDR_TMIN:      rdWord = tMinQ;
      gha_pkg::ADDR_AMBIENT:   rdWord = ambientQ;
      gha_pkg::ADDR_HEALTH:    rdWord = healthQ;
      gha_pkg::ADDR_UID_LO:    rdWord = nvmUserId[15:0];
      gha_pkg::ADDR_UID_HI:    rdWord = nvmUserId[31:16];
      default:                 rdWord = 16'h0;
    endcase
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  hot_flag_set_a: assert property (cellMeasValid && hotNow && opMode && !insertDetect
    |=> flagsQ[gha_pkg::FLAG_HIGH_TEMP_BIT]) else $error("flag not set");
  alarm_low_a: assert property (cellMeasValid && hotNow && opMode && !insertDetect
    |=> !alarm_out_n) else $error("alarm not driven");
  flag_sticky_a: assert property (flagsQ[gha_pkg::FLAG_HIGH_TEMP_BIT] && !clrAll
    && !(wrHit && wr.addr == gha_pkg::ADDR_FLAGS) && !insertDetect
    |=> flagsQ[gha_pkg::FLAG_HIGH_TEMP_BIT]) else $error("flag lost");
  alarm_disabled_a: assert property (!alarmEn |=> alarm_out_n)
    else $error("alarm while disabled");
  runtime_sat_a: assert property (runQ == gha_pkg::RUNTIME_SAT && !wrHit
    && !insertDetect |=> runQ == gha_pkg::RUNTIME_SAT) else $error("runtime wrapped");
  runtime_sleep_a: assert property (!opMode && !wrHit && !insertDetect
    |=> $stable(runQ) && $stable(cAccQ)) else $error("counted in sleep");
  charge_cap_a: assert property (cAccQ <= gha_pkg::CHARGE_SAT || $past(wrHit))
    else $error("charge above ceiling");
  vmax_track_a: assert property (cellMeasValid && opMode && !wrHit && !insertDetect
    && cellMeas.voltage > vMaxQ |=> vMaxQ == $past(cellMeas.voltage))
    else $error("peak voltage missed");
  vmin_track_a: assert property (cellMeasValid && opMode && !wrHit && !insertDetect
    && cellMeas.voltage < vMinQ |=> vMinQ == $past(cellMeas.voltage))
    else $error("low voltage missed");
  ambient_range_a: assert property (ambientQ >= gha_pkg::AMBIENT_MIN
    && ambientQ <= gha_pkg::AMBIENT_MAX) else $error("ambient out of range");
  init_ready_a: assert property ($rose(pwrQ == PwrInit)
    |-> !ready ##1 !ready) else $error("ready too early");
  runtime_atomic_a: assert property (wrHit && wr.addr == gha_pkg::ADDR_RUN_LO
    && !insertDetect |=> $stable(runQ) || $past(minuteTick))
    else $error("partial write took effect");

  cov_alarm_c: cover property (!alarm_out_n ##[1:100] alarm_out_n);
  cov_write_c: cover property (wrHit && wr.addr == gha_pkg::ADDR_RUN_HI);
  cov_ready_c: cover property ($rose(ready));
  cov_fast_c:  cover property ($rose(fastQ));
endmodule

// *** gha_host_model.sv ***
// two-wire host model for the gauge history and alarm register bank
// assumes the bench resolves the pulled-up data line from all drivers
`timescale 1ns/1ps
module gha_host_model (
  // clock and status
  input  wire logic ref_clk,
  input  wire logic ready,
  input  wire logic sdaLine,
  // bus drive
  output logic      sclOut,
  output logic      sdaLow
);
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick();
    repeat (4) @(negedge ref_clk);
  endtask
  // data moves a tick after clock falls, never mistaken for a start
  task automatic bitx(input logic b, output logic s);
    sdaLow = ~b;
    tick();
    sclOut = 1'b1;
    tick();
    s = sdaLine;
    sclOut = 1'b0;
    tick();
  endtask
  task automatic byte_io(input logic [7:0] v, input logic ackIn,
                         output logic [7:0] r, output logic ackOk);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(v[i], s);
      r[i] = s;
    end
    bitx(ackIn, s);
    ackOk = ~s;
  endtask
  task automatic start();
    sdaLow = 1'b0;
    tick();
    sclOut = 1'b1;
    tick();
    sdaLow = 1'b1;
    tick();
    sclOut = 1'b0;
    tick();
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    tick();
    sclOut = 1'b1;
    tick();
    sdaLow = 1'b0;
    tick();
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    logic [7:0] r;
    logic       a;
    wait (ready === 1'b1);
    start();
    byte_io(8'h54, 1'b1, r, a);
    byte_io(cmd, 1'b1, r, a);
    byte_io(d[7:0], 1'b1, r, a);
    byte_io(d[15:8], 1'b1, r, a);
    stop();
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
    logic a;
    wait (ready === 1'b1);
    start();
    byte_io(8'h54, 1'b1, d[7:0], a);
    byte_io(cmd, 1'b1, d[7:0], a);
    start();
    byte_io(8'h55, 1'b1, d[7:0], a);
    byte_io(8'hFF, 1'b0, d[7:0], a);
    byte_io(8'hFF, 1'b1, d[15:8], a);
    stop();
  endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the gauge history and alarm register bank
// assumes the host model above; shortened minute and init counts
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] TRK1 [4] = '{16'h1000, 16'h0F80, 16'h0C00, 16'h0B00};
  localparam logic [15:0] TRKW [4] = '{16'h0800, 16'h2000, 16'h0100, 16'h0F00};
  localparam logic [15:0] TRK2 [4] = '{16'h0900, 16'h0900, 16'h0200, 16'h0200};
  logic                ref_clk = 1'b0;
  logic                srst = 1'b1;
  logic                sclIn, sdaLow, sdaOut, sdaOe, alarm_out_n, ready, measReq;
  logic                insertDetect = 1'b0;
  logic                cellMeasValid = 1'b0;
  gha_pkg::gha_meas_s  cellMeas = '0;
  logic                ambientValid = 1'b0;
  logic [15:0]         ambientRaw = 16'h0000;
  logic                healthStep = 1'b0;
  logic [31:0]         nvmUserId = 32'h5A3CC3A5;
  logic [15:0]         powerMode = 16'h0002;
  logic [1:0]          thermCtrl = 2'b01;
  logic signed [15:0]  loadCurrent;
  logic signed [31:0]  chargeCount;
  wire                 sdaLine = ~sdaLow & ~(sdaOe & ~sdaOut);
  int                  comparisons = 0;
  int                  n_mismatch = 0;
  int                  nReq = 0;

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (measReq === 1'b1) nReq++;

  gha_regs #(.MINUTE_TICKS(50), .INIT_TICKS(5), .FAST_TICKS(4), .SLOW_TICKS(10)) gha_regs_inst (
    .ref_clk, .srst, .sclIn, .sdaIn(sdaLine), .sdaOut, .sdaOe, .insertDetect,
    .cellMeasValid, .cellMeas, .ambientValid, .ambientRaw, .healthStep, .nvmUserId,
    .powerMode, .thermCtrl, .alarm_out_n, .ready, .measReq, .loadCurrent, .chargeCount);

  gha_host_model gha_host_model_inst (.ref_clk, .ready, .sdaLine, .sclOut(sclIn), .sdaLow);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    gha_host_model_inst.rd(a, d);
    chk(d, e);
  endtask
  task automatic samp(input logic [15:0] v, input logic [15:0] t);
    @(negedge ref_clk);
    cellMeas = '{v, t, 16'h0F00, 16'h0010, 16'h0032};
    cellMeasValid = 1'b1;
    @(negedge ref_clk);
    cellMeasValid = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic amb(input logic [15:0] r);
    ambientRaw = r;
    ambientValid = 1'b1;
    @(negedge ref_clk);
    ambientValid = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // bound well above the expected run of roughly 24k cycles
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    chk(ready, 1'b0);
    samp(16'h1000, 16'h0C00);
    for (int i = 0; i < 100 && ready !== 1'b1; i++) @(negedge ref_clk);
    chk(ready, 1'b1);
    rdchk(8'h32, gha_pkg::HEALTH_INIT);
    rdchk(8'h30, gha_pkg::AMBIENT_MIN);
    rdchk(8'h2B, gha_pkg::VMIN_INIT);
    rdchk(8'h19, 16'h0000);
    $display("test reset done");
    gha_host_model_inst.wr(8'h24, 16'h0010);
    gha_host_model_inst.wr(8'h25, 16'h0000);
    gha_host_model_inst.wr(8'h28, 16'h0005);
    gha_host_model_inst.wr(8'h29, 16'h0000);
    gha_host_model_inst.wr(8'h24, 16'h1234);
    repeat (300) @(negedge ref_clk);
    rdchk(8'h24, 16'h0010);
    rdchk(8'h28, 16'h0005);
    $display("test sleep done");
    powerMode = gha_pkg::MODE_OPERATIONAL;
    gha_host_model_inst.wr(8'h21, 16'h0BB8);
    rdchk(8'h21, 16'h0BB8);
    samp(16'h1000, 16'h0C00);
    chk(alarm_out_n, 1'b0);
    chk(loadCurrent, 32'h0010);
    samp(16'h0F80, 16'h0B00);
    chk(alarm_out_n, 1'b1);
    rdchk(8'h19, 16'h1000);
    gha_host_model_inst.wr(8'h19, 16'h0000);
    rdchk(8'h19, 16'h0000);
    thermCtrl = 2'b00;
    samp(16'h1000, 16'h0C00);
    chk(alarm_out_n, 1'b1);
    thermCtrl = 2'b01;
    gha_host_model_inst.wr(8'h21, 16'h0000);
    samp(16'h1000, 16'h0C00);
    chk(alarm_out_n, 1'b1);
    gha_host_model_inst.wr(8'h21, 16'h0BB8);
    powerMode = gha_pkg::MODE_SLEEP;
    samp(16'h1000, 16'h0C00);
    chk(alarm_out_n, 1'b1);
    rdchk(8'h19, 16'h0000);
    powerMode = gha_pkg::MODE_OPERATIONAL;
    $display("test alarm done");
    for (int i = 0; i < 4; i++) rdchk(8'(8'h2A + i), TRK1[i]);
    for (int i = 0; i < 4; i++) gha_host_model_inst.wr(8'(8'h2A + i), TRKW[i]);
    samp(16'h0900, 16'h0200);
    chk(chargeCount, 32'hFFFFFFD8);
    for (int i = 0; i < 4; i++) rdchk(8'(8'h2A + i), TRK2[i]);
    $display("test trackers done");
    thermCtrl = 2'b11;
    amb(16'h0BB8);
    rdchk(8'h30, 16'h0BB8);
    amb(16'h0100);
    rdchk(8'h30, gha_pkg::AMBIENT_MIN);
    healthStep = 1'b1;
    @(negedge ref_clk);
    healthStep = 1'b0;
    rdchk(8'h32, 16'h0063);
    rdchk(8'h36, 16'hC3A5);
    rdchk(8'h37, 16'h5A3C);
    $display("test info done");
    gha_host_model_inst.wr(8'h24, 16'hFFFE);
    gha_host_model_inst.wr(8'h25, 16'h00FF);
    gha_host_model_inst.wr(8'h28, 16'hFFEF);
    gha_host_model_inst.wr(8'h29, 16'h0FFF);
    nReq = 0;
    repeat (300) @(negedge ref_clk);
    chk(nReq, 32'd75);
    rdchk(8'h24, 16'hFFFF);
    rdchk(8'h25, 16'h00FF);
    rdchk(8'h28, 16'hFFFF);
    rdchk(8'h29, 16'h0FFF);
    $display("test saturation done");
    end_of_test();
  end
endmodule
